/* File: rtl/lsc_map.svh */
// Register offsets, field positions, reset values and decode constants for the lane config block
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

`define LSC_CTRL_TWO_IDX      8'h07
`define LSC_CTRL_TWO_OFS      8'h1C
`define LSC_MASK_OFS          8'h40
`define LSC_MODE_OFS          8'h44
`define LSC_PLL_OFS           8'h48
`define LSC_CTRL_TWO_RST      16'hDC04
`define LSC_MASK_RST          4'h1
`define LSC_PLL_RST           4'h5
`define LSC_BIT_RSV_HI        15
`define LSC_SWING_HI          14
`define LSC_SWING_LO          12
`define LSC_BIT_LOS           11
`define LSC_BIT_IN_EN         10
`define LSC_IN_RATE_HI        9
`define LSC_IN_RATE_LO        8
`define LSC_DE_HI             7
`define LSC_DE_LO             4
`define LSC_BIT_RSV_LO        3
`define LSC_BIT_OUT_EN        2
`define LSC_OUT_RATE_HI       1
`define LSC_OUT_RATE_LO       0
`define LSC_MODE_TWO_TO_ONE   0
`define LSC_MODE_ONE_TO_TWO   1
`define LSC_MODE_GLOBAL_PD    2

`endif

/* File: rtl/lsc_pkg.sv */
// Types shared by the lane configuration block
package lsc_pkg;
   typedef enum logic [3:0] {
      LSC_RATE_FULL    = 4'h1,
      LSC_RATE_HALF    = 4'h2,
      LSC_RATE_QUARTER = 4'h4,
      LSC_RATE_RSV     = 4'h8
   } lsc_rate_e;

   typedef logic [15:0] lsc_word_t;

   typedef struct packed {
      lsc_word_t [3:0] lane;
      logic [3:0]      mask;
      logic [3:0]      pll_mpy;
      logic            two_to_one;
      logic            one_to_two;
      logic            global_pd;
   } lsc_state_s;
endpackage

/* File: rtl/lsc_lane_config.sv */
// Lane control register bank with APB slave and effective lane enable gating
`timescale 1ns/1ps
`include "lsc_map.svh"

module lsc_lane_config
   import lsc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        channel_powerdown_n,
   output logic      [3:0]  lane_input_enable,
   output logic      [3:0]  lane_output_enable,
   output logic      [3:0]  lane_signal_loss_detect_en,
   output logic      [11:0] lane_output_swing,
   output logic      [15:0] lane_output_deemphasis,
   output lsc_rate_e        lane_input_rate  [4],
   output lsc_rate_e        lane_output_rate [4],
   output logic      [9:0]  lane_pll_multiplier,
   output logic             lane_pll_code_reserved
);

   lsc_state_s st_r;
   lsc_state_s st_nxt;
   logic       wr_en;
   logic       rd_en;
   logic       addr_hit;
   logic [31:0] rd_data;
   logic [15:0] wr_word;
   logic        forced_off;
   // Byte map: 0x1C lane control, 0x40 select mask, 0x44 mode, 0x48 multiplier code

   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   assign pready = 1'b1;

   always_comb begin
      case (paddr)
         `LSC_CTRL_TWO_OFS,
         `LSC_MASK_OFS,
         `LSC_MODE_OFS,
         `LSC_PLL_OFS: addr_hit = 1'b1;
         default:      addr_hit = 1'b0;
      endcase
   end

   // Unmapped addresses answer with an error and change nothing
   assign pslverr = psel && penable && !addr_hit;

   // Byte strobes select which halves of the 16-bit word are written
   always_comb begin
      wr_word = st_r.lane[0];
      for (int i = 0; i < 4; i++) begin
         if (st_r.mask == 4'(1 << i)) begin
            wr_word = st_r.lane[i];
         end
      end
      if (pstrb[0]) begin
         wr_word[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
         wr_word[15:8] = pwdata[15:8];
      end
   end

   always_comb begin
      st_nxt = st_r;
      if (wr_en && pstrb[0]) begin
         case (paddr)
            `LSC_MASK_OFS: st_nxt.mask = pwdata[3:0];
            `LSC_MODE_OFS: begin
               st_nxt.two_to_one = pwdata[`LSC_MODE_TWO_TO_ONE];
               st_nxt.one_to_two = pwdata[`LSC_MODE_ONE_TO_TWO];
               st_nxt.global_pd  = pwdata[`LSC_MODE_GLOBAL_PD];
            end
            `LSC_PLL_OFS: st_nxt.pll_mpy = pwdata[3:0];
            default: ;
         endcase
      end
      if (wr_en && (paddr == `LSC_CTRL_TWO_OFS)) begin
         for (int i = 0; i < 4; i++) begin
            if (st_r.mask[i]) begin
               // Reserved bits 15 and 3 are stored like any other
               st_nxt.lane[i] = wr_word;
            end
         end
      end
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            st_nxt.lane[i] = `LSC_CTRL_TWO_RST;
         end
         st_nxt.mask       = `LSC_MASK_RST;
         st_nxt.pll_mpy    = `LSC_PLL_RST;
         st_nxt.two_to_one = 1'b0;
         st_nxt.one_to_two = 1'b0;
         st_nxt.global_pd  = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_r <= st_nxt;
   end

   // Readback of the selected lane; any mask other than one-hot reads zero
   always_comb begin
      rd_data = 32'h0;
      case (paddr)
         `LSC_CTRL_TWO_OFS: begin
            for (int i = 0; i < 4; i++) begin
               if (st_r.mask == 4'(1 << i)) begin
                  rd_data = {16'h0, st_r.lane[i]};
               end
            end
         end
         `LSC_MASK_OFS: rd_data = {28'h0, st_r.mask};
         `LSC_MODE_OFS: rd_data = {29'h0, st_r.global_pd, st_r.one_to_two, st_r.two_to_one};
         `LSC_PLL_OFS:  rd_data = {28'h0, st_r.pll_mpy};
         default:       rd_data = 32'h0;
      endcase
   end

   assign prdata = rd_en ? rd_data : 32'h0;

   logic        eff_in_en    [4];
   logic        eff_out_en   [4];
   logic        eff_los_en   [4];
   logic [2:0]  eff_swing    [4];
   logic [3:0]  eff_deemph   [4];
   lsc_rate_e   eff_in_rate  [4];
   lsc_rate_e   eff_out_rate [4];

   // Pin low or global power-down clears every lane's input and output enables
   assign forced_off = !channel_powerdown_n || st_r.global_pd;

   // One decoder per lane; the parameter marks lanes 3 and 2 as the pair the modes drop
   lsc_lane_decode #(
      .LANE (0)
   ) i_lane0 (
      .ctrl_word  (st_r.lane[0]),
      .forced_off (forced_off),
      .two_to_one (st_r.two_to_one),
      .one_to_two (st_r.one_to_two),
      .in_en      (eff_in_en[0]),
      .out_en     (eff_out_en[0]),
      .los_en     (eff_los_en[0]),
      .swing      (eff_swing[0]),
      .deemph     (eff_deemph[0]),
      .in_rate    (eff_in_rate[0]),
      .out_rate   (eff_out_rate[0])
   );

   lsc_lane_decode #(
      .LANE (1)
   ) i_lane1 (
      .ctrl_word  (st_r.lane[1]),
      .forced_off (forced_off),
      .two_to_one (st_r.two_to_one),
      .one_to_two (st_r.one_to_two),
      .in_en      (eff_in_en[1]),
      .out_en     (eff_out_en[1]),
      .los_en     (eff_los_en[1]),
      .swing      (eff_swing[1]),
      .deemph     (eff_deemph[1]),
      .in_rate    (eff_in_rate[1]),
      .out_rate   (eff_out_rate[1])
   );

   lsc_lane_decode #(
      .LANE (2)
   ) i_lane2 (
      .ctrl_word  (st_r.lane[2]),
      .forced_off (forced_off),
      .two_to_one (st_r.two_to_one),
      .one_to_two (st_r.one_to_two),
      .in_en      (eff_in_en[2]),
      .out_en     (eff_out_en[2]),
      .los_en     (eff_los_en[2]),
      .swing      (eff_swing[2]),
      .deemph     (eff_deemph[2]),
      .in_rate    (eff_in_rate[2]),
      .out_rate   (eff_out_rate[2])
   );

   lsc_lane_decode #(
      .LANE (3)
   ) i_lane3 (
      .ctrl_word  (st_r.lane[3]),
      .forced_off (forced_off),
      .two_to_one (st_r.two_to_one),
      .one_to_two (st_r.one_to_two),
      .in_en      (eff_in_en[3]),
      .out_en     (eff_out_en[3]),
      .los_en     (eff_los_en[3]),
      .swing      (eff_swing[3]),
      .deemph     (eff_deemph[3]),
      .in_rate    (eff_in_rate[3]),
      .out_rate   (eff_out_rate[3])
   );

   // Effective lane settings; stored enables are never altered by forcing
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_input_enable[i]             = eff_in_en[i];
         lane_output_enable[i]            = eff_out_en[i];
         lane_signal_loss_detect_en[i]    = eff_los_en[i];
         lane_output_swing[i*3 +: 3]      = eff_swing[i];
         lane_output_deemphasis[i*4 +: 4] = eff_deemph[i];
         lane_input_rate[i]               = eff_in_rate[i];
         lane_output_rate[i]              = eff_out_rate[i];
      end
   end

   // Multiplier factor in tenths so that 12.5 is exact; reserved codes give zero
   lsc_pll_decode i_pll (
      .code     (st_r.pll_mpy),
      .factor   (lane_pll_multiplier),
      .reserved (lane_pll_code_reserved)
   );

endmodule

// Multiplier code to factor in tenths; reserved codes give zero and raise the flag
module lsc_pll_decode (
   input  wire logic [3:0] code,
   output logic      [9:0] factor,
   output logic            reserved
);

   always_comb begin
      reserved = 1'b0;
      case (code)
         4'h0:    factor = 10'd40;
         4'h1:    factor = 10'd50;
         4'h2:    factor = 10'd60;
         4'h4:    factor = 10'd80;
         4'h5:    factor = 10'd100;
         4'h6:    factor = 10'd120;
         4'h7:    factor = 10'd125;
         4'h8:    factor = 10'd150;
         4'h9:    factor = 10'd200;
         4'hA:    factor = 10'd250;
         4'hD:    factor = 10'd500;
         4'hE:    factor = 10'd650;
         default: begin
            factor   = 10'd0;
            reserved = 1'b1;
         end
      endcase
   end

endmodule

// Two-bit rate code to one-hot rate; code 11 is reserved
module lsc_rate_decode
   import lsc_pkg::*;
(
   input  wire logic [1:0] code,
   output lsc_rate_e       rate
);

   always_comb begin
      case (code)
         2'h0:    rate = LSC_RATE_FULL;
         2'h1:    rate = LSC_RATE_HALF;
         2'h2:    rate = LSC_RATE_QUARTER;
         default: rate = LSC_RATE_RSV;
      endcase
   end

endmodule

// Per-lane decode of one stored control word into its effective settings
module lsc_lane_decode
   import lsc_pkg::*;
#(
   parameter int LANE = 0
)
(
   input  wire logic [15:0] ctrl_word,
   input  wire logic        forced_off,
   input  wire logic        two_to_one,
   input  wire logic        one_to_two,
   output logic             in_en,
   output logic             out_en,
   output logic             los_en,
   output logic      [2:0]  swing,
   output logic      [3:0]  deemph,
   output lsc_rate_e        in_rate,
   output lsc_rate_e        out_rate
);

   // Lanes 3 and 2 form the upper pair that the lane-count modes switch off
   localparam logic UPPER_PAIR = (LANE >= 2);

   logic in_pair_off;
   logic out_pair_off;

   assign in_pair_off  = two_to_one && UPPER_PAIR;
   assign out_pair_off = one_to_two && UPPER_PAIR;

   // Forcing gates the effective input and output enables only; loss detect is not gated
   assign in_en  = ctrl_word[`LSC_BIT_IN_EN] && !forced_off
                   && !in_pair_off;
   assign out_en = ctrl_word[`LSC_BIT_OUT_EN] && !forced_off
                   && !out_pair_off;
   assign los_en = ctrl_word[`LSC_BIT_LOS];
   assign swing  = ctrl_word[`LSC_SWING_HI:`LSC_SWING_LO];
   assign deemph = ctrl_word[`LSC_DE_HI:`LSC_DE_LO];

   lsc_rate_decode i_in_rate (
      .code (ctrl_word[`LSC_IN_RATE_HI:`LSC_IN_RATE_LO]),
      .rate (in_rate)
   );

   lsc_rate_decode i_out_rate (
      .code (ctrl_word[`LSC_OUT_RATE_HI:`LSC_OUT_RATE_LO]),
      .rate (out_rate)
   );

endmodule

/* File: verif/lsc_lane_config_props.sv */
// Concurrent checks on the lane config block ports
`timescale 1ns/1ps
module lsc_lane_config_props (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pslverr,
   input wire logic        channel_powerdown_n,
   input wire logic [3:0]  lane_input_enable,
   input wire logic [3:0]  lane_output_enable,
   input wire logic [3:0]  lane_signal_loss_detect_en,
   input wire logic [11:0] lane_output_swing,
   input wire logic [15:0] lane_output_deemphasis,
   input wire logic [9:0]  lane_pll_multiplier,
   input wire logic        lane_pll_code_reserved
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_in_pd; !channel_powerdown_n |-> lane_input_enable == 4'h0; endproperty
   a_in_pd: assert property (p_in_pd) else $error("input lane on in power-down");
   property p_out_pd; !channel_powerdown_n |-> lane_output_enable == 4'h0; endproperty
   a_out_pd: assert property (p_out_pd) else $error("output lane on in power-down");
   property p_rsv; lane_pll_code_reserved |-> lane_pll_multiplier == 10'h000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code gives a factor");
   property p_pll_rst; $past(sys_rst) |-> lane_pll_multiplier == 10'h064; endproperty
   a_pll_rst: assert property (p_pll_rst) else $error("multiplier reset wrong");
   property p_swing_rst; $past(sys_rst) |-> lane_output_swing == 12'hB6D; endproperty
   a_swing_rst: assert property (p_swing_rst) else $error("swing reset wrong");
   property p_los_rst; $past(sys_rst) |-> lane_signal_loss_detect_en == 4'hF; endproperty
   a_los_rst: assert property (p_los_rst) else $error("loss detect reset wrong");
   property p_de_rst; $past(sys_rst) |-> lane_output_deemphasis == 16'h0000; endproperty
   a_de_rst: assert property (p_de_rst) else $error("de-emphasis reset wrong");
   property p_err; psel && penable && paddr == 8'h1C |-> !pslverr; endproperty
   a_err: assert property (p_err) else $error("lane register access refused");
   c_pd: cover property (!channel_powerdown_n);
   c_rsv: cover property (lane_pll_code_reserved);
   c_err: cover property (psel && penable && pslverr);
endmodule
bind lsc_lane_config lsc_lane_config_props i_lsc_lane_config_props (.*);

/* File: verif/lsc_lane_config_bench.sv */
// Self-checking bench for the lane config block
`timescale 1ns/1ps
module lsc_lane_config_bench;
   import lsc_pkg::*;
   logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic        channel_powerdown_n = 1, pready, pslverr, lane_pll_code_reserved;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  pstrb = 0, ie, oe, mask, pllc;
   logic [3:0]  lane_input_enable, lane_output_enable, lane_signal_loss_detect_en;
   logic [11:0] lane_output_swing;
   logic [15:0] lane_output_deemphasis;
   lsc_rate_e   lane_input_rate [4], lane_output_rate [4];
   logic [9:0]  lane_pll_multiplier;
   logic [15:0] lane [4];
   logic [2:0]  mode;
   int          fails = 0, checks_done = 0, k;
   const int    pll_tab [16] = '{40, 50, 60, 0, 80, 100, 120, 125, 150, 200, 250, 0, 0, 500, 650, 0};
   lsc_lane_config i_lsc_lane_config (.*);
   always #25 core_clk = ~core_clk;
   task end_sim;
      $display("fails %0d checks %0d", fails, checks_done);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      end_sim;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'h3};
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task chk_all;
      #1;
      for (int i = 0; i < 4; i++) begin
         ie[i] = lane[i][10] & channel_powerdown_n & !mode[2] & !(mode[0] && i > 1);
         oe[i] = lane[i][2] & channel_powerdown_n & !mode[2] & !(mode[1] && i > 1);
         chk(lane_signal_loss_detect_en[i], lane[i][11]);
         chk(lane_output_swing[3*i+:3], lane[i][14:12]);
         chk(lane_output_deemphasis[4*i+:4], lane[i][7:4]);
         chk(lane_input_rate[i], 4'h1 << lane[i][9:8]);
         chk(lane_output_rate[i], 4'h1 << lane[i][1:0]);
      end
      chk(lane_input_enable, ie);
      chk(lane_output_enable, oe);
      chk(lane_pll_multiplier, pll_tab[pllc]);
      chk(lane_pll_code_reserved, pll_tab[pllc] == 0);
   endtask
   task rd_all;
      for (int i = 0; i < 4; i++) begin
         apb(1, 8'h40, 32'h1 << i);
         apb(0, 8'h1C, 0);
         chk(rd, {16'h0, lane[i]});
      end
      apb(1, 8'h40, mask);
   endtask
   task wl(input logic [3:0] m, input logic [15:0] v);
      apb(1, 8'h40, m);
      mask = m;
      apb(1, 8'h1C, v);
      for (int i = 0; i < 4; i++) if (m[i]) lane[i] = v;
      chk_all;
   endtask
   initial begin
      void'($urandom(66589));
      for (int i = 0; i < 4; i++) lane[i] = 16'hDC04;
      {mask, pllc, mode} = {4'h1, 4'h5, 3'h0};
      repeat (8) @(posedge core_clk);
      sys_rst <= 0;
      chk_all;
      rd_all;
      for (k = 0; k < 8; k++) begin
         wl(k < 4 ? 4'h1 << k : 4'($urandom_range(15, 1)), $urandom & 16'h7FF7 | 16'h8000);
         rd_all;
      end
      wl(4'hF, 16'hDC04);
      for (k = 0; k < 16; k++) begin
         apb(1, 8'h44, k & 7);
         mode = k[2:0];
         channel_powerdown_n <= !k[3];
         chk_all;
      end
      rd_all;
      channel_powerdown_n <= 1;
      for (k = 0; k < 16; k++) begin
         apb(1, 8'h48, k);
         pllc = k[3:0];
         chk_all;
      end
      apb(0, 8'h30, 0);
      chk(er, 1);
      chk(rd, 0);
      end_sim;
   end
endmodule
